// *** vtei_map.svh ***
// Register offsets, field positions and reset values of the supply-input
// and thermal/Type-C event block. Assumes an 8-bit register port with a
// 6-bit word address, as used throughout the device's register space.
// Operation
// R1: W1S at 0x16 sets supply-input event flags
// R2: Six supply-input flags raised by detector transitions
// R3: W1C at 0x17 clears supply-input event flags
// R4: W1S at 0x18 enables supply-input interrupts
// R5: W1C at 0x19 disables supply-input interrupts
// R6: Thermal flags, settable by write at 0x1A
// R7: CC1 and CC2 change flags, debug settable
// R8: W1C at 0x1B clears thermal/Type-C flags
// R9: W1S at 0x1C enables thermal/Type-C interrupts
// R10: W1C at 0x1D disables thermal/Type-C interrupts
// R11: Zero bits change nothing; pairs read state
// R12: Request while flag and enable; reset clears
`ifndef VTEI_MAP_SVH
`define VTEI_MAP_SVH

// Register word addresses
`define VTEI_SUP_EVT_SET 6'h16
`define VTEI_SUP_EVT_CLR 6'h17
`define VTEI_SUP_IEN_SET 6'h18
`define VTEI_SUP_IEN_CLR 6'h19
`define VTEI_THM_EVT_SET 6'h1a
`define VTEI_THM_EVT_CLR 6'h1b
`define VTEI_THM_IEN_SET 6'h1c
`define VTEI_THM_IEN_CLR 6'h1d

// Six flags used per group, upper two bits reserved
`define VTEI_NFLAG 6
`define VTEI_FLAGS_RST 6'h00
`define VTEI_RSVD_RD 2'h0
`define VTEI_ZERO8 8'h00

// Field positions, supply-input group
`define VTEI_SUPPLY_PRESENT 0
`define VTEI_SUPPLY_REMOVED 1
`define VTEI_OVERVOLTAGE_ON 2
`define VTEI_OVERVOLTAGE_OFF 3
`define VTEI_UNDERVOLTAGE_ON 4
`define VTEI_UNDERVOLTAGE_OFF 5
// Field positions, thermal/Type-C group
`define VTEI_HOT_WARNING_ON 0
`define VTEI_HOT_WARNING_OFF 1
`define VTEI_OVERHEAT_TRIP_ON 2
`define VTEI_OVERHEAT_TRIP_OFF 3
`define VTEI_CONFIG_LINE_ONE 4
`define VTEI_CONFIG_LINE_TWO 5

// Detector positions in the gathered level vector
`define VTEI_DET_PRESENT 0
`define VTEI_DET_OV 1
`define VTEI_DET_UV 2
`define VTEI_DET_WARN 3
`define VTEI_DET_TRIP 4
`define VTEI_DET_CC1 5
`define VTEI_DET_CC2 6
// Reset values of the detector pipeline and its warm-up marker
`define VTEI_DET_RST 7'h00
`define VTEI_WARM_RST 3'h0
`define VTEI_WARM_LAST 2
// Empty six-bit flag pattern
`define VTEI_ZERO6 6'h00

`endif

// *** vtei_pkg.sv ***
// Types shared by the event block files.
// Assumes the map header supplies the numbers.
package vtei_pkg;
	// One group's flag or enable vector
	typedef logic [5:0] vtei_flags_t;
endpackage

// *** vtei_group.sv ***
// One event group: six sticky flags and six interrupt enables, each with a
// set/clear register pair. Assumes synchronous one-cycle detector edge pulses and a
// one-cycle write strobe from the parent.
`include "vtei_map.svh"

module vtei_group (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [5:0] hw_set_i,
	input wire logic evt_set_we_i,
	input wire logic evt_clr_we_i,
	input wire logic ien_set_we_i,
	input wire logic ien_clr_we_i,
	input wire logic [5:0] wdata_i,
	output logic [5:0] flags_o,
	output logic [5:0] enables_o,
	output logic irq_o
);
	// Next values of the two vectors
	vtei_pkg::vtei_flags_t next_flags;
	vtei_pkg::vtei_flags_t next_enables;

	// Hardware or debug set wins over a clear in the same cycle
	always_comb begin
		next_flags = flags_o;
		if (evt_clr_we_i) begin
			next_flags = next_flags & ~wdata_i; // see R3 see R8 see R11
		end
		if (evt_set_we_i) begin
			next_flags = next_flags | wdata_i; // see R1 see R6 see R7
		end
		next_flags = next_flags | hw_set_i; // see R2 see R7
	end

	// Enable set/clear; a simultaneous pair never happens, clear is taken last
	always_comb begin
		next_enables = enables_o;
		if (ien_set_we_i) begin
			next_enables = next_enables | wdata_i; // see R4 see R9
		end
		if (ien_clr_we_i) begin
			next_enables = next_enables & ~wdata_i; // see R5 see R10
		end
	end

	// Flag storage
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flags_o <= `VTEI_FLAGS_RST; // see R12
		end else begin
			flags_o <= next_flags;
		end
	end

	// Enable storage
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			enables_o <= `VTEI_FLAGS_RST; // see R12
		end else begin
			enables_o <= next_enables;
		end
	end

	// Group request: any enabled pending flag
	assign irq_o = |(flags_o & enables_o); // see R12
endmodule // vtei_group

// *** vtei_irq.sv ***
// Supply-input and thermal/Type-C event flags with interrupt enables.
// Assumes detector levels arrive asynchronously from analog blocks and the
// register port is a simple synchronous 8-bit write/read port.
`include "vtei_map.svh"

module vtei_irq (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic supply_present_i,
	input wire logic overvoltage_i,
	input wire logic undervoltage_i,
	input wire logic hot_warning_i,
	input wire logic overheat_trip_i,
	input wire logic config_line_one_i,
	input wire logic config_line_two_i,
	input wire logic reg_we_i,
	input wire logic [5:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic irq_o
);
	// Seven detector levels gathered into one vector
	logic [6:0] det_raw;
	// Two-stage synchroniser
	logic [6:0] det_meta;
	logic [6:0] det_sync;
	// Previous synchronised level, for edge detection
	logic [6:0] det_prev;
	// Marks which pipeline stages hold post-reset samples
	logic [2:0] warm_pipe;
	// Edge masks valid once the previous level is a real sample
	logic prev_valid;
	logic [6:0] rise;
	logic [6:0] fall;
	logic [6:0] chg;
	// Per-group hardware set vectors
	logic [5:0] sup_hw;
	logic [5:0] thm_hw;
	// Group state and requests
	logic [5:0] sup_flags;
	logic [5:0] sup_ens;
	logic [5:0] thm_flags;
	logic [5:0] thm_ens;
	logic sup_irq;
	logic thm_irq;
	logic [7:0] next_rdata;
	// Decoded write strobes, one per register
	logic sup_evt_set_we;
	logic sup_evt_clr_we;
	logic sup_ien_set_we;
	logic sup_ien_clr_we;
	logic thm_evt_set_we;
	logic thm_evt_clr_we;
	logic thm_ien_set_we;
	logic thm_ien_clr_we;

	assign det_raw = {config_line_two_i, config_line_one_i, overheat_trip_i,
		hot_warning_i, undervoltage_i, overvoltage_i, supply_present_i};

	// Write strobe for one address
	function automatic logic hit(input logic [5:0] a);
		hit = reg_we_i && (reg_addr_i == a);
	endfunction

	// Strobes as plain signals, so assertions sample them like any net
	assign sup_evt_set_we = hit(`VTEI_SUP_EVT_SET); // see R1
	assign sup_evt_clr_we = hit(`VTEI_SUP_EVT_CLR); // see R3
	assign sup_ien_set_we = hit(`VTEI_SUP_IEN_SET); // see R4
	assign sup_ien_clr_we = hit(`VTEI_SUP_IEN_CLR); // see R5
	assign thm_evt_set_we = hit(`VTEI_THM_EVT_SET); // see R6
	assign thm_evt_clr_we = hit(`VTEI_THM_EVT_CLR); // see R8
	assign thm_ien_set_we = hit(`VTEI_THM_IEN_SET); // see R9
	assign thm_ien_clr_we = hit(`VTEI_THM_IEN_CLR); // see R10

	// Synchroniser; first stage feeds only the second
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			det_meta <= `VTEI_DET_RST;
			det_sync <= `VTEI_DET_RST;
		end else begin
			det_meta <= det_raw;
			det_sync <= det_meta;
		end
	end

	// Previous level; edges are masked until a real sample is held, so a
	// detector already high at reset does not raise a spurious event
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			det_prev <= `VTEI_DET_RST;
			warm_pipe <= `VTEI_WARM_RST;
		end else begin
			det_prev <= det_sync;
			warm_pipe <= {warm_pipe[1:0], 1'b1};
		end
	end

	// Three stages must refill: both synchroniser flops and the previous level.
	// Limitation: a change before the first post-reset sample is not flagged.
	assign prev_valid = warm_pipe[`VTEI_WARM_LAST];

	assign rise = prev_valid ? (det_sync & ~det_prev) : `VTEI_DET_RST;
	assign fall = prev_valid ? (~det_sync & det_prev) : `VTEI_DET_RST;
	assign chg = rise | fall;

	// Detected on rising level, removed on falling level
	assign sup_hw = {fall[`VTEI_DET_UV], rise[`VTEI_DET_UV], fall[`VTEI_DET_OV],
		rise[`VTEI_DET_OV], fall[`VTEI_DET_PRESENT], rise[`VTEI_DET_PRESENT]}; // see R2
	// CC lines flag any change of state
	assign thm_hw = {chg[`VTEI_DET_CC2], chg[`VTEI_DET_CC1], fall[`VTEI_DET_TRIP],
		rise[`VTEI_DET_TRIP], fall[`VTEI_DET_WARN], rise[`VTEI_DET_WARN]}; // see R6 see R7

	// Supply-input group
	vtei_group u_sup (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.hw_set_i(sup_hw),
		.evt_set_we_i(sup_evt_set_we), // see R1
		.evt_clr_we_i(sup_evt_clr_we), // see R3
		.ien_set_we_i(sup_ien_set_we), // see R4
		.ien_clr_we_i(sup_ien_clr_we), // see R5
		.wdata_i(reg_wdata_i[5:0]),
		.flags_o(sup_flags),
		.enables_o(sup_ens),
		.irq_o(sup_irq)
	);

	// Thermal and Type-C group
	vtei_group u_thm (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.hw_set_i(thm_hw),
		.evt_set_we_i(thm_evt_set_we), // see R6
		.evt_clr_we_i(thm_evt_clr_we), // see R8
		.ien_set_we_i(thm_ien_set_we), // see R9
		.ien_clr_we_i(thm_ien_clr_we), // see R10
		.wdata_i(reg_wdata_i[5:0]),
		.flags_o(thm_flags),
		.enables_o(thm_ens),
		.irq_o(thm_irq)
	);

	// Read mux: both registers of a pair show the same state
	always_comb begin
		unique case (reg_addr_i)
			`VTEI_SUP_EVT_SET, `VTEI_SUP_EVT_CLR: begin
				next_rdata = {`VTEI_RSVD_RD, sup_flags}; // see R11
			end
			`VTEI_SUP_IEN_SET, `VTEI_SUP_IEN_CLR: begin
				next_rdata = {`VTEI_RSVD_RD, sup_ens}; // see R11
			end
			`VTEI_THM_EVT_SET, `VTEI_THM_EVT_CLR: begin
				next_rdata = {`VTEI_RSVD_RD, thm_flags}; // see R11
			end
			`VTEI_THM_IEN_SET, `VTEI_THM_IEN_CLR: begin
				next_rdata = {`VTEI_RSVD_RD, thm_ens}; // see R11
			end
			default: begin
				// Unmapped addresses read zero
				next_rdata = `VTEI_ZERO8;
			end
		endcase
	end

	// Registered read data, one cycle after the address
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reg_rdata_o <= `VTEI_ZERO8;
		end else begin
			reg_rdata_o <= next_rdata;
		end
	end

	// Registered request keeps the output glitch free
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_o <= 1'b0; // see R12
		end else begin
			irq_o <= sup_irq | thm_irq; // see R12
		end
	end

	// Assertions
	irq_follows_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R12
		irq_o == $past(|(sup_flags & sup_ens) | |(thm_flags & thm_ens)))
		else $error("request does not follow enabled flags");
	sup_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R1
		sup_evt_set_we |=> ((sup_flags & $past(reg_wdata_i[5:0])) == $past(reg_wdata_i[5:0])))
		else $error("supply flag set failed");
	sup_clr_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R3
		sup_evt_clr_we && sup_hw == `VTEI_ZERO6
		|=> (sup_flags & $past(reg_wdata_i[5:0])) == `VTEI_ZERO6)
		else $error("supply flag clear failed");
	sup_ien_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R4
		sup_ien_set_we |=> sup_ens == ($past(sup_ens) | $past(reg_wdata_i[5:0])))
		else $error("supply enable set failed");
	sup_ien_clr_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R5
		sup_ien_clr_we |=> sup_ens == ($past(sup_ens) & ~$past(reg_wdata_i[5:0])))
		else $error("supply enable clear failed");
	sup_detect_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R2
		rise[`VTEI_DET_PRESENT] |=> sup_flags[`VTEI_SUPPLY_PRESENT])
		else $error("supply present not flagged");
	sup_remove_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R2
		fall[`VTEI_DET_PRESENT] |=> sup_flags[`VTEI_SUPPLY_REMOVED])
		else $error("supply removal not flagged");
	cc_change_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R7
		chg[`VTEI_DET_CC1] |=> thm_flags[`VTEI_CONFIG_LINE_ONE])
		else $error("line one change not flagged");
	cc_two_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R7
		chg[`VTEI_DET_CC2] |=> thm_flags[`VTEI_CONFIG_LINE_TWO])
		else $error("line two change not flagged");
	thm_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R6
		thm_evt_set_we |=> ((thm_flags & $past(reg_wdata_i[5:0])) == $past(reg_wdata_i[5:0])))
		else $error("thermal flag set failed");
	thm_clr_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R8
		thm_evt_clr_we && thm_hw == `VTEI_ZERO6
		|=> (thm_flags & $past(reg_wdata_i[5:0])) == `VTEI_ZERO6)
		else $error("thermal flag clear failed");
	thm_ien_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R9
		thm_ien_set_we |=> ((thm_ens & $past(reg_wdata_i[5:0])) == $past(reg_wdata_i[5:0])))
		else $error("thermal enable set failed");
	thm_ien_clr_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R10
		thm_ien_clr_we |=> (thm_ens & $past(reg_wdata_i[5:0])) == `VTEI_ZERO6)
		else $error("thermal enable clear failed");
	flags_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R11
		!reg_we_i && sup_hw == `VTEI_ZERO6 |=> sup_flags == $past(sup_flags))
		else $error("supply flags changed without cause");
	irq_seen_c: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(irq_o));
	ack_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
		irq_o ##1 sup_evt_clr_we ##2 !irq_o);
	overheat_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
		thm_flags[`VTEI_OVERHEAT_TRIP_ON]);
	// Detector edge and clear write in one cycle: the set must win
	race_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
		sup_evt_clr_we && sup_hw != `VTEI_ZERO6);
endmodule // vtei_irq

// *** tb_top.sv ***
// Self-checking testbench for the supply-input and thermal/Type-C event block.
// Assumes vtei_map.svh on the include path and the byte-wide register port.
`include "vtei_map.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk = 1'b0; // 40 MHz system clock
	logic rstn = 1'b0; // Reset, active low
	logic [6:0] det = 7'h00; // Detector levels: present, ov, uv, warn, trip, cc1, cc2
	logic we = 1'b0; // Write strobe
	logic [5:0] addr = 6'h00; // Word address
	logic [7:0] wdata = 8'h00; // Write data
	logic [7:0] rdata; // Registered read data
	logic irq; // Interrupt request
	logic [7:0] got; // Last value read back
	int bad_count = 0; // Mismatches seen
	int n_compared = 0; // Comparisons made

	// Half period of 12.5 ns
	always #12.5 clk = ~clk;

	vtei_irq i_dut (
		.clk_i(clk),
		.rstn_i(rstn),
		.supply_present_i(det[0]),
		.overvoltage_i(det[1]),
		.undervoltage_i(det[2]),
		.hot_warning_i(det[3]),
		.overheat_trip_i(det[4]),
		.config_line_one_i(det[5]),
		.config_line_two_i(det[6]),
		.reg_we_i(we),
		.reg_addr_i(addr),
		.reg_wdata_i(wdata),
		.reg_rdata_o(rdata),
		.irq_o(irq)
	);

	// Counts, verdict and end of run
	task automatic wrap_up;
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Byte comparison, four-state exact
	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Single-bit comparison, four-state exact
	task automatic chk_bit(input string what, input logic exp, input logic seen);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %s expected %b seen %b", what, exp, seen);
		end
	endtask

	// Always land 1 ns after a rising edge, so inputs never race the clock
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// One write; strobe dropped for a cycle so writes never merge
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		we = 1'b1;
		addr = a;
		wdata = d;
		tick(1);
		we = 1'b0;
		tick(1);
	endtask

	// Read data is registered: valid one edge after the address
	task automatic rd_chk(input string what, input logic [5:0] a, input logic [7:0] exp);
		addr = a;
		tick(1);
		got = rdata;
		chk_byte(what, exp, got);
	endtask

	// Every mapped register and an unmapped one read zero after reset
	task automatic t_reset;
		for (int i = 8'h16; i <= 8'h1d; i++) begin
			rd_chk("reset value", i[5:0], 8'h00);
		end
		rd_chk("unmapped read", 6'h20, 8'h00);
		chk_bit("irq idle", 1'b0, irq);
	endtask

	// Supply group: debug set, clear, zero writes, enables and request
	task automatic t_sup_regs;
		wr(`VTEI_SUP_EVT_SET, 8'hff);
		rd_chk("sup set", `VTEI_SUP_EVT_SET, 8'h3f);
		wr(`VTEI_SUP_EVT_CLR, 8'h05);
		rd_chk("sup clear", `VTEI_SUP_EVT_CLR, 8'h3a);
		wr(`VTEI_SUP_EVT_SET, 8'h00);
		rd_chk("sup zero write", `VTEI_SUP_EVT_SET, 8'h3a);
		wr(`VTEI_SUP_IEN_SET, 8'h3f);
		wr(`VTEI_SUP_IEN_CLR, 8'h0f);
		rd_chk("sup enable", `VTEI_SUP_IEN_SET, 8'h30);
		rd_chk("sup enable pair", `VTEI_SUP_IEN_CLR, 8'h30);
		chk_bit("sup irq on", 1'b1, irq);
		wr(`VTEI_SUP_EVT_CLR, 8'h30);
		chk_bit("sup irq off", 1'b0, irq);
		wr(`VTEI_SUP_EVT_CLR, 8'h3f);
		wr(`VTEI_SUP_IEN_CLR, 8'h3f);
	endtask

	// Thermal group registers, plus a stray write that must land nowhere
	task automatic t_thm_regs;
		wr(`VTEI_THM_EVT_SET, 8'h3f);
		rd_chk("thm set", `VTEI_THM_EVT_CLR, 8'h3f);
		wr(`VTEI_THM_IEN_SET, 8'h21);
		chk_bit("thm irq on", 1'b1, irq);
		wr(`VTEI_THM_IEN_CLR, 8'h21);
		chk_bit("thm irq off", 1'b0, irq);
		wr(6'h20, 8'hff);
		rd_chk("unmapped write", `VTEI_THM_IEN_SET, 8'h00);
		wr(`VTEI_THM_EVT_CLR, 8'h3f);
		rd_chk("thm clear", `VTEI_THM_EVT_SET, 8'h00);
	endtask

	// Each detector rises then falls; exactly one flag per edge
	task automatic t_detect;
		int pos;
		logic [5:0] a;
		for (int i = 0; i < 7; i++) begin
			for (int e = 0; e < 2; e++) begin
				det[i] = ~det[i];
				tick(6);
				pos = (i >= 5) ? i - 1 : ((i >= 3) ? 2 * (i - 3) + e : 2 * i + e);
				a = (i < 3) ? `VTEI_SUP_EVT_SET : `VTEI_THM_EVT_SET;
				rd_chk("detector flag", a, 8'h01 << pos);
				wr(a + 6'h01, 8'h3f);
			end
		end
	endtask

	// Reset in mid-run drops request, flags and enables
	task automatic t_reset_mid;
		wr(`VTEI_SUP_EVT_SET, 8'h01);
		wr(`VTEI_SUP_IEN_SET, 8'h01);
		chk_bit("irq before reset", 1'b1, irq);
		det[2] = 1'b1;
		rstn = 1'b0;
		tick(2);
		chk_bit("irq in reset", 1'b0, irq);
		rstn = 1'b1;
		tick(1);
		rd_chk("flags after reset", `VTEI_SUP_EVT_SET, 8'h00);
		rd_chk("enables after reset", `VTEI_SUP_IEN_SET, 8'h00);
		tick(2);
		rd_chk("reset level no event", `VTEI_SUP_EVT_SET, 8'h00);
		chk_bit("irq after reset", 1'b0, irq);
	endtask

	// Detector edge lands in the same cycle as a clear write: set wins
	task automatic t_race;
		det[0] = 1'b1;
		tick(2);
		wr(`VTEI_SUP_EVT_CLR, 8'h01);
		rd_chk("set beats clear", `VTEI_SUP_EVT_SET, 8'h01);
		det[0] = 1'b0;
		tick(6);
		wr(`VTEI_SUP_EVT_CLR, 8'h3f);
		rd_chk("race cleanup", `VTEI_SUP_EVT_SET, 8'h00);
	endtask

	// Main sequence; reset held for ten cycles
	initial begin
		tick(10);
		rstn = 1'b1;
		tick(1);
		t_reset;
		t_sup_regs;
		t_thm_regs;
		t_detect;
		t_race;
		t_reset_mid;
		wrap_up;
	end

	// Watchdog: tests need a few hundred cycles, allow four thousand
	initial begin
		#100000;
		bad_count++;
		$display("FAIL watchdog expected finish seen hang");
		wrap_up;
	end
endmodule // tb_top
